// [verilog/sspm_pkg.sv]
package sspm_pkg;
  // ****************************************************************
  // clock source selection codes (low nibble of port_control_one)
  // ****************************************************************
  localparam logic [3:0] SSPM_CLK_FOSC4 = 4'h0;
  localparam logic [3:0] SSPM_CLK_FOSC16 = 4'h1;
  localparam logic [3:0] SSPM_CLK_FOSC64 = 4'h2;
  localparam logic [3:0] SSPM_CLK_TMR2 = 4'h3;
  localparam logic [3:0] SSPM_MODE_I2CM = 4'h8;
  // ****************************************************************
  // field positions and sizes
  // ****************************************************************
  localparam int SSPM_PEN_BIT = 5;
  localparam int SSPM_CKP_BIT = 4;
  localparam int SSPM_BITS = 8;
  localparam logic [3:0] SSPM_BIT_LAST = 4'h7;
  localparam logic [3:0] SSPM_I2C_RECOV_CLKS = 4'h9;
  localparam logic [5:0] SSPM_DIV_FOSC4 = 6'h01;
  localparam logic [5:0] SSPM_DIV_FOSC16 = 6'h07;
  localparam logic [5:0] SSPM_DIV_FOSC64 = 6'h1f;
  localparam logic [5:0] SSPM_DIV_I2C = 6'h03;
endpackage

// [verilog/sspm_clk_if.sv]
`timescale 1ns/100ps
interface sspm_clk_if;
  logic tick;
  logic [3:0] sel;
  logic tmr_match;
  logic run;
  modport gen (input sel, input tmr_match, input run, output tick);
  modport use_side (output sel, output tmr_match, output run, input tick);
endinterface

// [verilog/sspm_clkgen.sv]
`timescale 1ns/100ps
module sspm_clkgen
  import sspm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  sspm_clk_if.gen cif
);
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } sspm_cg_t;
  sspm_cg_t s_reg, s_next;

  // divider limit per selected source
  function automatic logic [5:0] div_of(input logic [3:0] sel);
    case (sel)
      SSPM_CLK_FOSC16: div_of = SSPM_DIV_FOSC16;
      SSPM_CLK_FOSC64: div_of = SSPM_DIV_FOSC64;
      SSPM_MODE_I2CM: div_of = SSPM_DIV_I2C;
      default: div_of = SSPM_DIV_FOSC4;
    endcase
  endfunction

  // half-period tick: timer source ticks on each match
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!cif.run) begin
      s_next.cnt = 6'h00;
    end else if (cif.sel == SSPM_CLK_TMR2) begin
      s_next.tick = cif.tmr_match; // R9
    end else if (s_reg.cnt >= div_of(cif.sel)) begin
      s_next.cnt = 6'h00;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign cif.tick = s_reg.tick;

  tmr_tick_a: assert property (@(posedge clk_in) disable iff (rst_in) // R9
    cif.run && cif.sel == SSPM_CLK_TMR2 && cif.tmr_match |=> cif.tick)
    else $error("timer match did not give a clock tick");
endmodule

// [verilog/sspm_top.sv]
`timescale 1ns/100ps
// Behaviour
// [R1] low nibble 0011 of port_control_one selects timer-two/2 as SPI clock
// [R2] timer clock with edge select one: first data bit with first edge, level short
// [R3] edge select clear, sample phase set: final bit 0 sampled wrongly
// [R4] Stop mid-reception in I2C receive: SCL runs endlessly, receive enable stays
// [R5] later Start gives nine more SCL clocks then clears receive enable
// [R6] clearing port enable releases stuck receive enable, receiver goes idle
// [R7] software should avoid the timer-two/2 clock source
// [R8] software should run a time-out during I2C master reception
// [R9] timer source toggles the serial clock once per timer-two match
module sspm_top
  import sspm_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // control
  input wire logic [7:0] PORT_CONTROL_ONE_IN,
  input wire logic CLK_EDGE_SEL_IN,
  input wire logic INPUT_SAMPLE_PHASE_IN,
  input wire logic [7:0] TX_DATA_IN,
  input wire logic TX_LOAD_IN,
  input wire logic RECEIVE_ENABLE_SET_IN,
  input wire logic TMR2_MATCH_IN,
  // serial link
  input wire logic SERIAL_DATA_IN_IN,
  input wire logic SDA_IN,
  input wire logic SCL_IN,
  output logic SCK_OUT,
  output logic SERIAL_DATA_OUT_OUT,
  output logic SCL_OUT,
  output logic SCL_OE_OUT,
  // status
  output logic [7:0] RX_DATA_OUT,
  output logic DONE_OUT,
  output logic BUSY_OUT,
  output logic RECEIVE_ENABLE_BIT_OUT
);
  typedef enum {ST_IDLE, ST_SPI, ST_I2C_RX, ST_RUNAWAY, ST_RECOVER} sspm_state_t;
  typedef struct packed {
    sspm_state_t st;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [3:0] bitn;
    logic [3:0] recov;
    logic phase;
    logic first;
    logic sck;
    logic serial_data_out;
    logic scl_oe;
    logic receive_enable_bit;
    logic done;
    logic sda_d;
    logic scl_d;
    logic busy;
  } sspm_top_t;
  sspm_top_t s_reg, s_next;

  sspm_clk_if cif();
  logic port_en;
  logic [3:0] mode;
  logic idle_lvl;
  logic tmr_mode;
  logic stop_seen;
  logic start_seen;

  // ****************************************************************
  // control decode
  // ****************************************************************
  assign port_en = PORT_CONTROL_ONE_IN[SSPM_PEN_BIT];
  assign mode = PORT_CONTROL_ONE_IN[3:0];
  assign idle_lvl = PORT_CONTROL_ONE_IN[SSPM_CKP_BIT];
  assign tmr_mode = (mode == SSPM_CLK_TMR2); // R1
  assign stop_seen = SCL_IN && s_reg.scl_d && SDA_IN && !s_reg.sda_d;
  assign start_seen = SCL_IN && s_reg.scl_d && !SDA_IN && s_reg.sda_d;

  assign cif.sel = mode;
  assign cif.tmr_match = TMR2_MATCH_IN;
  assign cif.run = (s_reg.st != ST_IDLE);

  sspm_clkgen sspm_clkgen_i (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .cif(cif.gen)
  );

  // ****************************************************************
  // transfer state machine
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.sda_d = SDA_IN;
    s_next.scl_d = SCL_IN;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.sck = idle_lvl;
        s_next.scl_oe = 1'b0;
        if (port_en && mode == SSPM_MODE_I2CM && (RECEIVE_ENABLE_SET_IN || s_reg.receive_enable_bit)) begin
          s_next.receive_enable_bit = 1'b1;
          s_next.bitn = 4'h0;
          s_next.phase = 1'b0;
          s_next.st = ST_I2C_RX;
        end else if (port_en && mode != SSPM_MODE_I2CM && TX_LOAD_IN) begin
          s_next.sh = TX_DATA_IN;
          s_next.bitn = 4'h0;
          s_next.phase = 1'b0;
          s_next.first = 1'b1;
          // edge select clear: first bit is presented before any edge
          if (!CLK_EDGE_SEL_IN) begin
            s_next.serial_data_out = TX_DATA_IN[SSPM_BITS-1];
          end else if (!tmr_mode) begin
            s_next.serial_data_out = TX_DATA_IN[SSPM_BITS-1];
          end
          s_next.st = ST_SPI;
        end
      end
      ST_SPI: begin
        // timer source with edge select one: first bit leaves with first edge
        if (s_reg.first && tmr_mode && CLK_EDGE_SEL_IN) begin
          s_next.serial_data_out = s_reg.sh[SSPM_BITS-1]; // R2
          s_next.sck = !idle_lvl; // R2
          s_next.phase = 1'b1;
          s_next.first = 1'b0;
          if (INPUT_SAMPLE_PHASE_IN == 1'b0) begin
            s_next.sh = {s_reg.sh[6:0], SERIAL_DATA_IN_IN};
          end
        end else if (cif.tick) begin
          s_next.first = 1'b0;
          s_next.sck = !s_reg.sck;
          s_next.phase = !s_reg.phase;
          if (!s_reg.phase) begin
            // leading edge: sample (middle phase) only; data out changes on the trailing edge
            if (!INPUT_SAMPLE_PHASE_IN) begin
              s_next.sh = {s_reg.sh[6:0], SERIAL_DATA_IN_IN};
            end
          end else begin
            // trailing edge: end-phase sample, bit 0 lost when edge select clear
            if (INPUT_SAMPLE_PHASE_IN) begin
              if (s_reg.bitn == SSPM_BIT_LAST && !CLK_EDGE_SEL_IN) begin
                s_next.sh = {s_reg.sh[6:0], s_reg.sh[0]}; // R3
              end else begin
                s_next.sh = {s_reg.sh[6:0], SERIAL_DATA_IN_IN};
              end
            end
            s_next.serial_data_out = s_next.sh[SSPM_BITS-1];
            if (s_reg.bitn == SSPM_BIT_LAST) begin
              s_next.rx = s_next.sh;
              s_next.done = 1'b1;
              s_next.sck = idle_lvl;
              s_next.st = ST_IDLE;
            end else begin
              s_next.bitn = s_reg.bitn + 4'h1;
            end
          end
        end
        if (!port_en) begin
          s_next.st = ST_IDLE;
        end
      end
      ST_I2C_RX: begin
        s_next.scl_oe = 1'b1;
        if (stop_seen) begin
          s_next.st = ST_RUNAWAY; // R4
        end else if (cif.tick) begin
          s_next.sck = !s_reg.sck;
          s_next.phase = !s_reg.phase;
          if (s_reg.phase) begin
            s_next.sh = {s_reg.sh[6:0], SDA_IN};
            if (s_reg.bitn == SSPM_BIT_LAST) begin
              s_next.rx = {s_reg.sh[6:0], SDA_IN};
              s_next.done = 1'b1;
              s_next.receive_enable_bit = 1'b0;
              s_next.st = ST_IDLE;
            end else begin
              s_next.bitn = s_reg.bitn + 4'h1;
            end
          end
        end
      end
      ST_RUNAWAY: begin
        // endless clocking, receive enable held
        s_next.scl_oe = 1'b1;
        s_next.receive_enable_bit = 1'b1; // R4
        if (cif.tick) begin
          s_next.sck = !s_reg.sck; // R4
        end
        if (start_seen) begin
          s_next.recov = 4'h0;
          s_next.phase = 1'b0;
          s_next.st = ST_RECOVER; // R5
        end
      end
      ST_RECOVER: begin
        s_next.scl_oe = 1'b1;
        if (cif.tick) begin
          s_next.sck = !s_reg.sck;
          s_next.phase = !s_reg.phase;
          if (s_reg.phase) begin
            if (s_reg.recov == SSPM_I2C_RECOV_CLKS - 4'h1) begin
              s_next.receive_enable_bit = 1'b0; // R5
              s_next.st = ST_IDLE;
            end else begin
              s_next.recov = s_reg.recov + 4'h1; // R5
            end
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    // disabling the port clears receive enable and the SCL drive and returns to idle
    if (!port_en) begin
      s_next.receive_enable_bit = 1'b0; // R6
      s_next.scl_oe = 1'b0;
      s_next.st = ST_IDLE; // R6
    end
    // busy kept in a flop so the status output is registered
    s_next.busy = (s_next.st != ST_IDLE);
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s_reg <= '{st: ST_IDLE, sda_d: 1'b1, scl_d: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign SCK_OUT = s_reg.sck;
  assign SERIAL_DATA_OUT_OUT = s_reg.serial_data_out;
  assign SCL_OUT = s_reg.sck;
  assign SCL_OE_OUT = s_reg.scl_oe;
  assign RX_DATA_OUT = s_reg.rx;
  assign DONE_OUT = s_reg.done;
  assign BUSY_OUT = s_reg.busy;
  assign RECEIVE_ENABLE_BIT_OUT = s_reg.receive_enable_bit;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence runaway_s;
    s_reg.st == ST_RUNAWAY && start_seen && port_en;
  endsequence

  sel_timer_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R1
    s_reg.st == ST_SPI && tmr_mode |=> cif.tick == $past(TMR2_MATCH_IN))
    else $error("timer source not selected as clock");
  first_edge_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R2
    s_reg.st == ST_SPI && s_reg.first && tmr_mode && CLK_EDGE_SEL_IN && port_en
    |=> SCK_OUT == !idle_lvl && SERIAL_DATA_OUT_OUT == $past(s_reg.sh[7]))
    else $error("first bit not with first edge");
  stop_runaway_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R4
    s_reg.st == ST_I2C_RX && stop_seen && port_en |=> s_reg.st == ST_RUNAWAY)
    else $error("stop did not cause runaway");
  receive_enable_bit_held_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R4
    s_reg.st == ST_RUNAWAY && port_en |=> RECEIVE_ENABLE_BIT_OUT)
    else $error("receive enable dropped while runaway");
  recover_start_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R5
    runaway_s |=> s_reg.st == ST_RECOVER && s_reg.recov == 4'h0)
    else $error("start did not begin recovery");
  recover_end_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R5
    $fell(RECEIVE_ENABLE_BIT_OUT) && $past(s_reg.st == ST_RECOVER) && $past(port_en)
    |-> $past(s_reg.recov) == 4'h8)
    else $error("receive enable cleared after wrong clock count");
  disable_rel_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R6
    !port_en |=> !RECEIVE_ENABLE_BIT_OUT && !SCL_OE_OUT && !BUSY_OUT)
    else $error("port disable did not release receiver");
  last_bit_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R3
    s_reg.st == ST_SPI && cif.tick && s_reg.phase && s_reg.bitn == 4'h7
    && INPUT_SAMPLE_PHASE_IN && !CLK_EDGE_SEL_IN && port_en
    |=> RX_DATA_OUT[0] == $past(s_reg.sh[0]))
    else $error("final bit sampled from pin");
endmodule

// [testbench/sspm_spi_slave.sv]
`timescale 1ns/100ps
module sspm_spi_slave (
  // serial link
  input wire logic sck_in,
  input wire logic sdo_in,
  // byte framing
  input wire logic start_in,
  input wire logic [7:0] reply_in,
  output logic sdi_out,
  output logic [7:0] got_out
);
  logic [7:0] shift;
  int n;
  // a new byte shows its msb before any clock edge
  always @(posedge start_in) begin
    shift = reply_in;
    n = 0;
    sdi_out = reply_in[7];
  end
  // capture the master's data on the leading edge
  always @(posedge sck_in) begin
    got_out = {got_out[6:0], sdo_in};
  end
  // advance on the trailing edge; past the byte show no stale level
  always @(negedge sck_in) begin
    n = n + 1;
    shift = {shift[6:0], 1'b0};
    sdi_out = (n < 8) ? shift[7] : ~sdi_out;
  end
endmodule

// [testbench/sync_serial_port_master_test.sv]
`timescale 1ns/100ps
module sync_serial_port_master_test;
  import sspm_pkg::*;
  logic clk, rst, cke, input_sample_phase, load, rcv_set, match, sda, start, serial_data_in;
  logic sck, serial_data_out, scl_o, scl_oe, done, busy, receive_enable_bit, f_sck, f_sdo, prev_sck;
  logic [7:0] ctl, tx, rx, reply, got;
  wire scl_line;
  int n_fail, n_tests, n_tog, n_match, cnt;
  // open-drain clock line with pull-up
  assign scl_line = scl_oe ? scl_o : 1'b1;
  sspm_top sspm_top_i (.CLK_IN(clk), .RST_IN(rst), .PORT_CONTROL_ONE_IN(ctl),
    .CLK_EDGE_SEL_IN(cke), .INPUT_SAMPLE_PHASE_IN(input_sample_phase), .TX_DATA_IN(tx),
    .TX_LOAD_IN(load), .RECEIVE_ENABLE_SET_IN(rcv_set), .TMR2_MATCH_IN(match),
    .SERIAL_DATA_IN_IN(serial_data_in), .SDA_IN(sda), .SCL_IN(scl_line), .SCK_OUT(sck),
    .SERIAL_DATA_OUT_OUT(serial_data_out), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .RX_DATA_OUT(rx),
    .DONE_OUT(done), .BUSY_OUT(busy), .RECEIVE_ENABLE_BIT_OUT(receive_enable_bit));
  sspm_spi_slave sspm_spi_slave_i (.sck_in(sck), .sdo_in(serial_data_out), .start_in(start),
    .reply_in(reply), .sdi_out(serial_data_in), .got_out(got));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wrap_up;
    $display("counts: compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task spi_byte(input logic [7:0] c, input logic e, input logic s, input logic [7:0] d,
                input logic [7:0] r);
    int i;
    @(posedge clk);
    ctl <= c; cke <= e; input_sample_phase <= s; reply <= r; tx <= d;
    @(posedge clk);
    start <= 1'b1; load <= 1'b1;
    n_tog = 0; n_match = 0; prev_sck = sck;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      load <= 1'b0; start <= 1'b0;
      match <= (c[3:0] == SSPM_CLK_TMR2) && (i % 6 == 5);
      if ((c[3:0] == SSPM_CLK_TMR2) && (i % 6 == 5)) n_match++;
      @(negedge clk);
      if (sck !== prev_sck) n_tog++;
      prev_sck = sck;
      if (i == 1) begin
        f_sck = sck; f_sdo = serial_data_out;
      end
      if (done === 1'b1) break;
    end
    match <= 1'b0;
    check("done", {7'h00, done}, 8'h01);
  endtask
  task wait_scl(input logic v);
    int i;
    for (i = 0; i < 100 && scl_line !== v; i++) @(negedge clk);
    if (scl_line !== v) n_fail++;
  endtask
  task count_rise(input int lim, input logic until_clr);
    int i;
    logic p;
    cnt = 0;
    p = scl_line;
    for (i = 0; i < lim; i++) begin
      @(negedge clk);
      if (scl_line === 1'b1 && p === 1'b0) cnt++;
      p = scl_line;
      if (until_clr && receive_enable_bit === 1'b0) break;
    end
  endtask
  task i2c_stop_mid;
    @(posedge clk);
    ctl <= 8'h28; sda <= 1'b1; rcv_set <= 1'b1;
    @(posedge clk);
    rcv_set <= 1'b0;
    wait_scl(1'b0); wait_scl(1'b1); wait_scl(1'b0);
    @(posedge clk);
    sda <= 1'b0;
    wait_scl(1'b1);
    @(posedge clk);
    sda <= 1'b1;
    count_rise(400, 1'b0);
    check("receive_enable_bit held", {7'h00, receive_enable_bit}, 8'h01);
    check("runaway", {7'h00, cnt > 30}, 8'h01);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task test_reset;
    @(negedge clk);
    check("reset outs", {2'b00, sck, serial_data_out, scl_oe, done, busy, receive_enable_bit}, 8'h00);
    $display("test reset done");
  endtask
  task test_spi_plain;
    int m;
    // fixed divider sources in normal use
    for (m = 0; m < 3; m++) begin
      spi_byte(8'h20 | 8'(m), 1'b0, 1'b0, 8'hA5 ^ 8'(m), 8'h3C + 8'(m));
      check("rx", rx, 8'h3C + 8'(m));
      check("slave got", got, 8'hA5 ^ 8'(m));
    end
    $display("test spi plain done");
  endtask
  task test_last_bit;
    spi_byte(8'h20, 1'b0, 1'b1, 8'h00, 8'h5E);
    check("rx upper", {1'b0, rx[7:1]}, 8'h2F);
    check("rx bit0", {7'h00, rx[0]}, 8'h01);
    $display("test last bit done");
  endtask
  task test_timer;
    spi_byte(8'h23, 1'b0, 1'b0, 8'hC3, 8'h96);
    check("matches", 8'(n_match), 8'h10);
    check("sck toggles", 8'(n_tog), 8'h10);
    check("slave got", got, 8'hC3);
    check("timer rx", rx, 8'h96);
    spi_byte(8'h23, 1'b1, 1'b0, 8'h81, 8'h00);
    check("first edge", {6'h00, f_sck, f_sdo}, 8'h03);
    $display("test timer done");
  endtask
  task test_restart;
    i2c_stop_mid();
    // land on the first high cycle so SCL stays high while the start is seen
    wait_scl(1'b0);
    wait_scl(1'b1);
    @(posedge clk);
    sda <= 1'b0;
    count_rise(1000, 1'b1);
    check("extra clocks", 8'(cnt), 8'h09);
    check("receive_enable_bit cleared", {7'h00, receive_enable_bit}, 8'h00);
    $display("test restart done");
  endtask
  task test_disable;
    @(posedge clk);
    ctl <= 8'h08; sda <= 1'b1;
    i2c_stop_mid();
    @(posedge clk);
    ctl <= 8'h08;
    repeat (3) @(negedge clk);
    check("released", {5'h00, receive_enable_bit, scl_oe, busy}, 8'h00);
    $display("test disable done");
  endtask
  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  // reset, then each scenario in turn
  initial begin
    n_fail = 0; n_tests = 0;
    rst = 1'b1; ctl = 8'h00; cke = 1'b0; input_sample_phase = 1'b0; tx = 8'h00; load = 1'b0;
    rcv_set = 1'b0; match = 1'b0; sda = 1'b1; start = 1'b0; reply = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_spi_plain();
    test_last_bit();
    test_timer();
    test_restart();
    test_disable();
    wrap_up();
  end
endmodule
